/* shared/pxb_cfg.svh */
// Constants for the primary bridge status register block
`ifndef PXB_CFG_SVH
`define PXB_CFG_SVH

`define PXB_CMD_CFG_WR    4'hB
`define PXB_STAT_DWORD    6'h21
`define PXB_DEV_RST       5'h1F
`define PXB_FUNC_RST      3'h0
`define PXB_BUS_LSB       8
`define PXB_DEV_LSB       3
`define PXB_PRI64_BIT     16
`define PXB_PRI133_BIT    17
`define PXB_USC_BIT       19
`define PXB_SRD_BIT       21
`define PXB_FLAG_BE       2

`endif

/* shared/pxb_pkg.sv */
// Types shared by the link side and the status register core
package pxb_pkg;

  // One link event, held stable while its toggle crosses domains
  typedef struct packed {
    logic        cfg_wr;
    logic [4:0]  dev;
    logic        clr_usc;
    logic        clr_srd;
    logic        spc;
    logic [15:0] rid;
  } pxb_evt_t;

  // Address-phase capture of a config write aimed at this bridge
  typedef struct packed {
    logic       pend;
    logic [4:0] dev;
    logic [5:0] dword;
  } pxb_addr_t;

endpackage

/* verilog/pxb_link_side.sv */
// Primary bus facing logic on the link clock: decode, capture, read shadow
`timescale 1ns/1ps
`include "pxb_cfg.svh"
module pxb_link_side
  import pxb_pkg::*;
#(
  parameter logic [2:0] FUNC_NUM = `PXB_FUNC_RST
) (
  // Link clock and reset
  input  wire logic        lnk_clk_i,
  input  wire logic        rst_i,
  // Primary bus phases
  input  wire logic        lnk_adr_vld_i,
  input  wire logic        lnk_dat_vld_i,
  input  wire logic [3:0]  lnk_cmd_i,
  input  wire logic        lnk_idsel_i,
  input  wire logic [31:0] lnk_ad_i,
  input  wire logic [3:0]  lnk_be_i,
  input  wire logic        lnk_spc_vld_i,
  input  wire logic [15:0] lnk_spc_rid_i,
  // Towards the core
  output pxb_evt_t         evt_o,
  output logic             evt_tog_o,
  // Status snapshot from the core
  input  wire logic [31:0] snap_i,
  input  wire logic        snap_req_i,
  output logic             snap_ack_o,
  output logic [31:0]      lnk_rdata_o
);

  pxb_addr_t   adr_r, adr_nxt;
  pxb_evt_t    evt_r, evt_nxt;
  logic        tog_r, tog_nxt;
  logic        q1_r, q2_r, q3_r;
  logic        ack_r, ack_nxt;
  logic [31:0] shd_r, shd_nxt;
  logic        hit;
  logic        flag_wr;

  always_comb begin
    hit = lnk_adr_vld_i && lnk_cmd_i == `PXB_CMD_CFG_WR && lnk_idsel_i
          && lnk_ad_i[1:0] == 2'h0 && lnk_ad_i[10:8] == FUNC_NUM;
    flag_wr = adr_r.dword == `PXB_STAT_DWORD && lnk_be_i[`PXB_FLAG_BE];
    adr_nxt = adr_r;
    evt_nxt = evt_r;
    tog_nxt = tog_r;
    if (lnk_adr_vld_i) begin
      adr_nxt.pend  = hit;
      adr_nxt.dev   = lnk_ad_i[15:11];
      adr_nxt.dword = lnk_ad_i[7:2];
    end else if (lnk_dat_vld_i && adr_r.pend) begin
      adr_nxt.pend    = 1'b0;
      evt_nxt.cfg_wr  = 1'b1;
      evt_nxt.dev     = adr_r.dev;
      evt_nxt.clr_usc = flag_wr && lnk_ad_i[`PXB_USC_BIT];
      evt_nxt.clr_srd = flag_wr && lnk_ad_i[`PXB_SRD_BIT];
      evt_nxt.spc     = 1'b0;
      evt_nxt.rid     = 16'h0000;
      tog_nxt         = ~tog_r;
    end else if (lnk_spc_vld_i) begin
      evt_nxt.cfg_wr  = 1'b0;
      evt_nxt.clr_usc = 1'b0;
      evt_nxt.clr_srd = 1'b0;
      evt_nxt.spc     = 1'b1;
      evt_nxt.rid     = lnk_spc_rid_i;
      tog_nxt         = ~tog_r;
    end
  end

  always_ff @(posedge lnk_clk_i or posedge rst_i) begin
    if (rst_i) begin
      adr_r <= '0;
      evt_r <= '0;
      tog_r <= 1'b0;
    end else begin
      adr_r <= adr_nxt;
      evt_r <= evt_nxt;
      tog_r <= tog_nxt;
    end
  end

  // Snapshot handshake; shadow loads only once the request toggle settled
  always_comb begin
    shd_nxt = shd_r;
    ack_nxt = ack_r;
    if (q2_r == q3_r && q3_r != ack_r) begin
      shd_nxt = snap_i;
      ack_nxt = q3_r;
    end
  end

  always_ff @(posedge lnk_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q1_r  <= 1'b0;
      q2_r  <= 1'b0;
      q3_r  <= 1'b0;
      ack_r <= 1'b0;
      shd_r <= 32'h0000_0000;
    end else begin
      q1_r  <= snap_req_i;
      q2_r  <= q1_r;
      q3_r  <= q2_r;
      ack_r <= ack_nxt;
      shd_r <= shd_nxt;
    end
  end

  assign evt_o       = evt_r;
  assign evt_tog_o   = tog_r;
  assign snap_ack_o  = ack_r;
  assign lnk_rdata_o = shd_r;

  default clocking cb_lnk @(posedge lnk_clk_i); endclocking
  default disable iff (rst_i);

  property p_no_false_hit;
    lnk_adr_vld_i && !(lnk_cmd_i == `PXB_CMD_CFG_WR && lnk_idsel_i
      && lnk_ad_i[1:0] == 2'h0 && lnk_ad_i[10:8] == FUNC_NUM) |=> !adr_r.pend;
  endproperty
  a_no_false_hit: assert property (p_no_false_hit)
    else $error("Address phase not aimed at bridge was taken as config write");

endmodule

/* verilog/pxb_status_reg.sv */
// Primary bridge status register core with its link side instance
//
// Overview of operation
// - Config writes to the bridge load device number from AD[15:11]; resets 11111.
// - Bridge write needs config write command, IDSEL, type 0, matching function.
// - Bits 15:8 mirror the primary bus number register.
// - Completer ID is built from bus, device and function numbers.
// - Bits 16 and 17 are read-only and read zero.
// - Split completion carrying bridge's own ID sets bit 19; write one clears.
// - Split request held back by commitment limit sets bit 21; write one clears.
`timescale 1ns/1ps
`include "pxb_cfg.svh"
module pxb_status_reg
  import pxb_pkg::*;
#(
  parameter logic [2:0] FUNC_NUM = `PXB_FUNC_RST
) (
  // System clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Primary bus side
  input  wire logic        lnk_clk_i,
  input  wire logic        lnk_adr_vld_i,
  input  wire logic        lnk_dat_vld_i,
  input  wire logic [3:0]  lnk_cmd_i,
  input  wire logic        lnk_idsel_i,
  input  wire logic [31:0] lnk_ad_i,
  input  wire logic [3:0]  lnk_be_i,
  input  wire logic        lnk_spc_vld_i,
  input  wire logic [15:0] lnk_spc_rid_i,
  output logic [31:0]      lnk_rdata_o,
  // Bridge internals
  input  wire logic [7:0]  pri_bus_num_i,
  input  wire logic        spl_req_dly_i,
  output logic [31:0]      status_o,
  output logic [15:0]      cmpl_id_o
);

  pxb_evt_t    evt;
  logic        evt_tog;
  logic        snap_ack;
  logic        e1_r, e2_r, e3_r;
  logic        seen_r, seen_nxt;
  logic        take;
  logic        uexp;
  logic [4:0]  dev_r, dev_nxt;
  logic        usc_r, usc_nxt;
  logic        srd_r, srd_nxt;
  logic [31:0] stat_r, stat_nxt;
  logic [15:0] cid_r, cid_nxt;
  logic        a1_r, a2_r, a3_r;
  logic [31:0] snap_r, snap_nxt;
  logic        sreq_r, sreq_nxt;

  function automatic logic [31:0] build_word(input logic [7:0] bus,
                                             input logic [4:0] dev,
                                             input logic [2:0] fn,
                                             input logic       usc,
                                             input logic       srd);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[2:0] = fn;
    w[`PXB_DEV_LSB +: 5] = dev;
    w[`PXB_BUS_LSB +: 8] = bus;
    w[`PXB_USC_BIT] = usc;
    w[`PXB_SRD_BIT] = srd;
    return w;
  endfunction

  pxb_link_side #(
    .FUNC_NUM (FUNC_NUM)
  ) u_link (
    .lnk_clk_i     (lnk_clk_i),
    .rst_i         (rst_i),
    .lnk_adr_vld_i (lnk_adr_vld_i),
    .lnk_dat_vld_i (lnk_dat_vld_i),
    .lnk_cmd_i     (lnk_cmd_i),
    .lnk_idsel_i   (lnk_idsel_i),
    .lnk_ad_i      (lnk_ad_i),
    .lnk_be_i      (lnk_be_i),
    .lnk_spc_vld_i (lnk_spc_vld_i),
    .lnk_spc_rid_i (lnk_spc_rid_i),
    .evt_o         (evt),
    .evt_tog_o     (evt_tog),
    .snap_i        (snap_r),
    .snap_req_i    (sreq_r),
    .snap_ack_o    (snap_ack),
    .lnk_rdata_o   (lnk_rdata_o)
  );

  // Event toggle crossing; data is held still on the link side meanwhile
  always_comb begin
    take     = e2_r == e3_r && e3_r != seen_r;
    seen_nxt = take ? e3_r : seen_r;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      e1_r   <= 1'b0;
      e2_r   <= 1'b0;
      e3_r   <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      e1_r   <= evt_tog;
      e2_r   <= e1_r;
      e3_r   <= e2_r;
      seen_r <= seen_nxt;
    end
  end

  // Register state; a set arriving with its clear wins
  always_comb begin
    uexp    = take && evt.spc
              && evt.rid == {pri_bus_num_i, dev_r, FUNC_NUM};
    dev_nxt = (take && evt.cfg_wr) ? evt.dev : dev_r;
    usc_nxt = uexp || (usc_r && !(take && evt.cfg_wr && evt.clr_usc));
    srd_nxt = spl_req_dly_i
              || (srd_r && !(take && evt.cfg_wr && evt.clr_srd));
    stat_nxt = build_word(pri_bus_num_i, dev_r, FUNC_NUM, usc_r, srd_r);
    cid_nxt  = {pri_bus_num_i, dev_r, FUNC_NUM};
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_r  <= `PXB_DEV_RST;
      usc_r  <= 1'b0;
      srd_r  <= 1'b0;
      stat_r <= 32'h0000_0000;
      cid_r  <= 16'h0000;
    end else begin
      dev_r  <= dev_nxt;
      usc_r  <= usc_nxt;
      srd_r  <= srd_nxt;
      stat_r <= stat_nxt;
      cid_r  <= cid_nxt;
    end
  end

  // Snapshot to the link; only one update in flight so the shadow never tears
  always_comb begin
    snap_nxt = snap_r;
    sreq_nxt = sreq_r;
    if (a2_r == a3_r && a3_r == sreq_r && stat_r != snap_r) begin
      snap_nxt = stat_r;
      sreq_nxt = ~sreq_r;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      a1_r   <= 1'b0;
      a2_r   <= 1'b0;
      a3_r   <= 1'b0;
      snap_r <= 32'h0000_0000;
      sreq_r <= 1'b0;
    end else begin
      a1_r   <= snap_ack;
      a2_r   <= a1_r;
      a3_r   <= a2_r;
      snap_r <= snap_nxt;
      sreq_r <= sreq_nxt;
    end
  end

  assign status_o  = stat_r;
  assign cmpl_id_o = cid_r;

  default clocking cb_sys @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_dev_load;
    take && evt.cfg_wr |=> dev_r == $past(evt.dev) ##1 status_o[7:3] == $past(evt.dev, 2);
  endproperty
  a_dev_load: assert property (p_dev_load)
    else $error("Device number not loaded from config write");

  property p_bus_mirror;
    ##1 status_o[15:8] == $past(pri_bus_num_i);
  endproperty
  a_bus_mirror: assert property (p_bus_mirror)
    else $error("Bus number field does not follow primary bus number");

  property p_cmpl_id;
    ##1 cmpl_id_o == {status_o[15:8], status_o[7:3], status_o[2:0]};
  endproperty
  a_cmpl_id: assert property (p_cmpl_id)
    else $error("Completer ID differs from bus, device and function fields");

  property p_cap_zero;
    status_o[`PXB_PRI64_BIT] == 1'b0 && status_o[`PXB_PRI133_BIT] == 1'b0;
  endproperty
  a_cap_zero: assert property (p_cap_zero)
    else $error("Capability bits not zero");

  property p_usc_set;
    uexp |=> usc_r ##1 status_o[`PXB_USC_BIT];
  endproperty
  a_usc_set: assert property (p_usc_set)
    else $error("Unexpected split completion flag not set");

  property p_usc_clr;
    take && evt.cfg_wr && evt.clr_usc && !uexp |=> !usc_r;
  endproperty
  a_usc_clr: assert property (p_usc_clr)
    else $error("Unexpected split completion flag not cleared by write one");

  property p_srd_set;
    spl_req_dly_i |=> srd_r ##1 status_o[`PXB_SRD_BIT];
  endproperty
  a_srd_set: assert property (p_srd_set)
    else $error("Split request delayed flag not set");

  property p_srd_hold;
    srd_r && !(take && evt.cfg_wr && evt.clr_srd) |=> srd_r;
  endproperty
  a_srd_hold: assert property (p_srd_hold)
    else $error("Split request delayed flag dropped without a clear");

  property p_rsvd_zero;
    status_o[31:22] == 10'h000 && !status_o[18] && !status_o[20];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("Reserved or unsupported status bit not zero");

endmodule

/* bench/pxb_host_model.sv */
// Primary bus host model: config writes and split completions
`timescale 1ns/1ps
module pxb_host_model (
  // Link clock
  input  wire logic        lnk_clk_i,
  // Bus phases
  output logic             adr_vld_o,
  output logic             dat_vld_o,
  output logic [3:0]       cmd_o,
  output logic             idsel_o,
  output logic [31:0]      ad_o,
  output logic [3:0]       be_o,
  output logic             spc_vld_o,
  output logic [15:0]      rid_o
);
  initial begin
    adr_vld_o = 1'b0;
    dat_vld_o = 1'b0;
    cmd_o     = 4'h0;
    idsel_o   = 1'b0;
    ad_o      = 32'h5A5A_5A5A;
    be_o      = 4'h0;
    spc_vld_o = 1'b0;
    rid_o     = 16'h0000;
  end

  // Address then data phase; trailing idle edge keeps events at least 3 clocks apart
  task automatic cfg(input logic [3:0] cmd, input logic sel, input logic [31:0] adr,
                     input logic [3:0] be, input logic [31:0] dat);
    @(negedge lnk_clk_i);
    adr_vld_o <= 1'b1;
    cmd_o     <= cmd;
    idsel_o   <= sel;
    ad_o      <= adr;
    @(negedge lnk_clk_i);
    adr_vld_o <= 1'b0;
    idsel_o   <= 1'b0;
    cmd_o     <= ~cmd;
    dat_vld_o <= 1'b1;
    be_o      <= be;
    ad_o      <= dat;
    @(negedge lnk_clk_i);
    dat_vld_o <= 1'b0;
    be_o      <= 4'h0;
    // Released bus shows garbage, not the last data
    ad_o      <= ~dat;
    @(negedge lnk_clk_i);
  endtask

  task automatic spc(input logic [15:0] id);
    @(negedge lnk_clk_i);
    spc_vld_o <= 1'b1;
    rid_o     <= id;
    @(negedge lnk_clk_i);
    spc_vld_o <= 1'b0;
    rid_o     <= ~id;
    @(negedge lnk_clk_i);
  endtask
endmodule

/* bench/pxb_status_reg_bench.sv */
// Self-checking bench for the primary bridge status register
`timescale 1ns/1ps
`include "pxb_cfg.svh"
module pxb_status_reg_bench;
  localparam logic [2:0] FN = 3'h5;
  logic        sys_clk_i = 1'b0;
  logic        lnk_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [7:0]  pri_bus_num_i = 8'h00;
  logic        spl_req_dly_i = 1'b0;
  logic        adr_vld, dat_vld, idsel, spc_vld;
  logic [3:0]  cmd, be;
  logic [31:0] ad, lnk_rdata_o, status_o;
  logic [15:0] rid, cmpl_id_o;
  logic [4:0]  dev = 5'h1F;
  logic        usc = 1'b0;
  logic        srd = 1'b0;
  int          err_count = 0;
  int          tests_run = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;
  always #80 lnk_clk_i = ~lnk_clk_i;

  pxb_status_reg #(.FUNC_NUM(FN)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .lnk_clk_i(lnk_clk_i),
    .lnk_adr_vld_i(adr_vld), .lnk_dat_vld_i(dat_vld), .lnk_cmd_i(cmd),
    .lnk_idsel_i(idsel), .lnk_ad_i(ad), .lnk_be_i(be), .lnk_spc_vld_i(spc_vld),
    .lnk_spc_rid_i(rid), .lnk_rdata_o(lnk_rdata_o), .pri_bus_num_i(pri_bus_num_i),
    .spl_req_dly_i(spl_req_dly_i), .status_o(status_o), .cmpl_id_o(cmpl_id_o));

  pxb_host_model i_host (
    .lnk_clk_i(lnk_clk_i), .adr_vld_o(adr_vld), .dat_vld_o(dat_vld), .cmd_o(cmd),
    .idsel_o(idsel), .ad_o(ad), .be_o(be), .spc_vld_o(spc_vld), .rid_o(rid));

  function automatic logic [31:0] exp_word();
    return {10'h000, srd, 1'b0, usc, 3'h0, pri_bus_num_i, dev, FN};
  endfunction

  function automatic logic [31:0] adr(logic [4:0] d, logic [2:0] f, logic [5:0] dw,
                                      logic [1:0] ty);
    return {16'h0000, d, f, dw, ty};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hold first when the expected outcome is no change at all
  task automatic settle(input bit hold);
    int n;
    logic [31:0] w;
    w = exp_word();
    if (hold) repeat (40) @(negedge sys_clk_i);
    for (n = 0; n < 100; n++) begin
      if (status_o === w && lnk_rdata_o === w) break;
      @(negedge sys_clk_i);
    end
    chk(status_o, w);
    chk(lnk_rdata_o, w);
    chk({16'h0000, cmpl_id_o}, {16'h0000, w[15:0]});
    if (n == 100) begin
      // Bound used up: counts against the run even if the last look matched
      err_count++;
      conclude();
    end
  endtask

  task automatic t_write();
    dev = 5'h0A;
    i_host.cfg(`PXB_CMD_CFG_WR, 1'b1, adr(dev, FN, `PXB_STAT_DWORD, 2'h0), 4'hF,
               32'hFFFF_FFFF);
    settle(1'b0);
    dev = 5'h13;
    i_host.cfg(`PXB_CMD_CFG_WR, 1'b1, adr(dev, FN, 6'h02, 2'h0), 4'hF, 32'h0000_0000);
    settle(1'b0);
    $display("test write done");
  endtask

  task automatic t_miss();
    for (int k = 0; k < 4; k++)
      i_host.cfg(k == 0 ? 4'hA : `PXB_CMD_CFG_WR, k != 1,
                 adr(5'h07, k == 3 ? ~FN : FN, `PXB_STAT_DWORD, k == 2 ? 2'h1 : 2'h0),
                 4'hF, 32'h0000_0000);
    settle(1'b1);
    $display("test decode done");
  endtask

  task automatic t_bus();
    @(negedge sys_clk_i);
    pri_bus_num_i = 8'hA5;
    settle(1'b0);
    $display("test bus done");
  endtask

  task automatic t_flags();
    i_host.spc({pri_bus_num_i, dev, FN ^ 3'h1});
    settle(1'b1);
    i_host.spc({pri_bus_num_i, dev, FN});
    usc = 1'b1;
    settle(1'b0);
    @(negedge sys_clk_i);
    spl_req_dly_i = 1'b1;
    @(negedge sys_clk_i);
    spl_req_dly_i = 1'b0;
    srd = 1'b1;
    settle(1'b0);
    // Byte lane 2 off: clear must not land
    i_host.cfg(`PXB_CMD_CFG_WR, 1'b1, adr(dev, FN, `PXB_STAT_DWORD, 2'h0), 4'hB,
               32'h0028_0000);
    settle(1'b1);
    i_host.cfg(`PXB_CMD_CFG_WR, 1'b1, adr(dev, FN, `PXB_STAT_DWORD, 2'h0), 4'h4,
               32'h0008_0000);
    usc = 1'b0;
    settle(1'b0);
    // Delay still asserted while the clear lands: the set must win
    @(negedge sys_clk_i);
    spl_req_dly_i = 1'b1;
    i_host.cfg(`PXB_CMD_CFG_WR, 1'b1, adr(dev, FN, `PXB_STAT_DWORD, 2'h0), 4'h4,
               32'h0020_0000);
    @(negedge sys_clk_i);
    spl_req_dly_i = 1'b0;
    settle(1'b1);
    i_host.cfg(`PXB_CMD_CFG_WR, 1'b1, adr(dev, FN, `PXB_STAT_DWORD, 2'h0), 4'h4,
               32'h0020_0000);
    srd = 1'b0;
    settle(1'b0);
    $display("test flags done");
  endtask

  initial begin
    // Asynchronous reset; release kept clear of any link clock edge
    repeat (8) @(negedge sys_clk_i);
    rst_i = 1'b0;
    settle(1'b0);
    $display("test reset done");
    t_write();
    t_miss();
    t_bus();
    t_flags();
    conclude();
  end
endmodule
